/* File: logic/vmrs_top.sv */
/*
 * Mode latch, reference target select, soft-start sequencer and current balance.
 * Assumes all pin inputs synchronous to pclk and an APB master on the register port.
 */
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module vmrs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_in,
    input wire logic por_ok,
    input wire logic mode_select_pin,
    input wire logic [5:0] par_code,
    input wire logic serial_code_clock,
    input wire logic serial_code_data,
    input wire logic power_ok_input,
    input wire logic fixed_voltage_strap,
    input wire logic [3:0][7:0] cur_sample,
    output logic core_enable,
    output logic northbridge_plane_enable,
    output vmrs_pkg::vmrs_ref_t ref_out,
    output logic power_good_output,
    output logic serial_code_mode,
    output logic [3:0][7:0] pulse_width
);
    // ****************************************
    // state
    // ****************************************
    logic en_d_ff;
    logic par_mode_ff;
    logic ser_mode_ff;
    logic [7:0] startup_ff;
    logic [7:0] hold_ff;
    vmrs_pkg::vmrs_state_t state_ff;
    vmrs_pkg::vmrs_state_t nxt_state;
    vmrs_pkg::vmrs_ref_t ref_ff;
    vmrs_pkg::vmrs_ref_t nxt_ref;
    logic [7:0] step_cnt_ff;
    logic pgood_ff;
    logic core_en_ff;
    logic nb_en_ff;
    logic [2:0] ch_cnt_ff;
    logic [7:0] base_pw_ff;
    logic [15:0] cyc_per_ff;
    logic [15:0] cyc_cnt_ff;
    logic [9:0] avg_ff;
    logic [3:0][7:0] pw_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // ****************************************
    // decode
    // ****************************************
    wire en_rise = enable_in & ~en_d_ff;
    wire par_lo = par_code >= vmrs_pkg::PAR_LO_FIRST;
    wire [7:0] par_off = {2'b00, par_code};
    wire [7:0] par_hi_ref = vmrs_pkg::REF_PAR_HI_TOP - (par_off << 1);
    wire [7:0] par_lo_ref = vmrs_pkg::REF_PAR_LO_TOP
        - (par_off - {2'b00, vmrs_pkg::PAR_LO_FIRST});
    wire [7:0] par_ref = par_lo ? par_lo_ref : par_hi_ref;
    wire [1:0] svi_bits = {serial_code_clock, serial_code_data};
    wire [7:0] startup_dec = (svi_bits == 2'b00) ? vmrs_pkg::REF_1V1 :
                             (svi_bits == 2'b01) ? vmrs_pkg::REF_1V0 :
                             (svi_bits == 2'b10) ? vmrs_pkg::REF_0V9 :
                             vmrs_pkg::REF_0V8;
    wire [7:0] fixed_dec = (svi_bits == 2'b00) ? vmrs_pkg::REF_1V4 :
                           (svi_bits == 2'b01) ? vmrs_pkg::REF_1V2 :
                           (svi_bits == 2'b10) ? vmrs_pkg::REF_1V0 :
                           vmrs_pkg::REF_0V8;
    // fixed strap decodes live; otherwise the held startup target, power-ok high or low
    wire [7:0] svi_tgt = fixed_voltage_strap ? fixed_dec : hold_ff;
    wire [7:0] core_tgt = par_mode_ff ? par_ref : svi_tgt;
    wire [7:0] nb_tgt = par_mode_ff ? vmrs_pkg::REF_ZERO : svi_tgt;
    wire active = (state_ff == vmrs_pkg::ST_RAMP) || (state_ff == vmrs_pkg::ST_REG);
    wire [7:0] core_aim = active ? core_tgt : vmrs_pkg::REF_ZERO;
    wire [7:0] nb_aim = active ? nb_tgt : vmrs_pkg::REF_ZERO;
    wire step_tick = step_cnt_ff == vmrs_pkg::STEP_LAST;
    wire at_target = (ref_ff.core == core_tgt) && (ref_ff.nb == nb_tgt);
    wire at_zero = (ref_ff.core == vmrs_pkg::REF_ZERO) && (ref_ff.nb == vmrs_pkg::REF_ZERO);

    function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] aim);
        if (cur < aim)
        begin
            step_to = cur + vmrs_pkg::REF_STEP;
        end
        else if (cur > aim)
        begin
            step_to = cur - vmrs_pkg::REF_STEP;
        end
        else
        begin
            step_to = cur;
        end
    endfunction

    always_comb
    begin
        nxt_ref = ref_ff;
        if (step_tick)
        begin
            nxt_ref.core = step_to(ref_ff.core, core_aim);
            nxt_ref.nb = step_to(ref_ff.nb, nb_aim);
        end
    end

    always_comb
    begin
        case (state_ff)
            vmrs_pkg::ST_OFF: nxt_state = en_rise ? vmrs_pkg::ST_RAMP : vmrs_pkg::ST_OFF;
            vmrs_pkg::ST_RAMP:
            begin
                if (!enable_in)
                begin
                    nxt_state = vmrs_pkg::ST_DOWN;
                end
                else if (at_target)
                begin
                    nxt_state = vmrs_pkg::ST_REG;
                end
                else
                begin
                    nxt_state = vmrs_pkg::ST_RAMP;
                end
            end
            vmrs_pkg::ST_REG: nxt_state = enable_in ? vmrs_pkg::ST_REG : vmrs_pkg::ST_DOWN;
            vmrs_pkg::ST_DOWN:
            begin
                if (en_rise)
                begin
                    nxt_state = vmrs_pkg::ST_RAMP;
                end
                else if (at_zero)
                begin
                    nxt_state = vmrs_pkg::ST_OFF;
                end
                else
                begin
                    nxt_state = vmrs_pkg::ST_DOWN;
                end
            end
            default: nxt_state = vmrs_pkg::ST_OFF;
        endcase
    end

    // ****************************************
    // mode latch and sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_d_ff <= 1'b0;
            par_mode_ff <= 1'b0;
            ser_mode_ff <= 1'b1;
            startup_ff <= vmrs_pkg::REF_ZERO;
            hold_ff <= vmrs_pkg::REF_ZERO;
        end
        else
        begin
            en_d_ff <= enable_in;
            if (!enable_in)
            begin
                par_mode_ff <= mode_select_pin;
                ser_mode_ff <= !mode_select_pin;
            end
            if (por_ok)
            begin
                startup_ff <= startup_dec;
            end
            if (en_rise)
            begin
                hold_ff <= startup_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= vmrs_pkg::ST_OFF;
            ref_ff <= '0;
            step_cnt_ff <= '0;
            pgood_ff <= 1'b0;
            core_en_ff <= 1'b0;
            nb_en_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ref_ff <= nxt_ref;
            step_cnt_ff <= step_tick ? 8'h00 : step_cnt_ff + 8'h01;
            pgood_ff <= enable_in && (nxt_state == vmrs_pkg::ST_REG);
            core_en_ff <= enable_in;
            nb_en_ff <= enable_in && !par_mode_ff;
        end
    end

    // ****************************************
    // current balance
    // ****************************************
    wire cyc_tick = cyc_cnt_ff >= cyc_per_ff;
    logic [9:0] cur_sum;
    always_comb
    begin
        cur_sum = '0;
        for (int i = 0; i < vmrs_pkg::NUM_CH; i++)
        begin
            if (3'(i) < ch_cnt_ff)
            begin
                cur_sum = cur_sum + {2'b00, cur_sample[i]};
            end
        end
    end
    wire [9:0] cur_avg = (ch_cnt_ff == vmrs_pkg::CH_MIN) ? (cur_sum >> 1) :
                         (ch_cnt_ff == vmrs_pkg::CH_MAX) ? (cur_sum >> 2) :
                         10'(cur_sum / 10'h003);

    wire [3:0][7:0] nxt_pw;
    genvar g;
    generate
        for (g = 0; g < vmrs_pkg::NUM_CH; g++)
        begin : g_ch
            wire signed [11:0] trim = $signed({4'h0, base_pw_ff}) + $signed({2'b00, cur_avg})
                - $signed({4'h0, cur_sample[g]});
            wire [7:0] clip = trim[11] ? 8'h00 : (|trim[10:8]) ? 8'hff : trim[7:0];
            wire ch_on = 3'(g) < ch_cnt_ff;
            assign nxt_pw[g] = ch_on ? clip : 8'h00;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc_cnt_ff <= '0;
            avg_ff <= '0;
            pw_ff <= '0;
        end
        else
        begin
            cyc_cnt_ff <= cyc_tick ? 16'h0000 : cyc_cnt_ff + 16'h0001;
            if (cyc_tick)
            begin
                avg_ff <= cur_avg;
                pw_ff <= nxt_pw;
            end
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    wire setup = psel && !penable;
    wire wr_go = psel && penable && pwrite && pready_ff;
    wire hit_ctrl = paddr == vmrs_pkg::ADDR_CTRL;
    wire hit_cycle = paddr == vmrs_pkg::ADDR_CYCLE;
    wire hit_status = paddr == vmrs_pkg::ADDR_STATUS;
    wire hit_avg = paddr == vmrs_pkg::ADDR_AVG;
    wire hit_any = hit_ctrl || hit_cycle || hit_status || hit_avg;
    wire [2:0] wr_cnt = pwdata[vmrs_pkg::CTRL_CNT_LSB +: 3];
    wire cnt_ok = (wr_cnt >= vmrs_pkg::CH_MIN) && (wr_cnt <= vmrs_pkg::CH_MAX);
    wire [31:0] rd_status = {8'h00, ref_ff.nb, ref_ff.core, 4'h0, pgood_ff, ~par_mode_ff,
        state_ff};
    wire [31:0] rd_ctrl = {16'h0000, base_pw_ff, 5'h00, ch_cnt_ff};
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                         hit_cycle ? {16'h0000, cyc_per_ff} :
                         hit_status ? rd_status :
                         hit_avg ? {22'h000000, avg_ff} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= 1'b1;
            if (setup)
            begin
                pslverr_ff <= !hit_any;
                prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch_cnt_ff <= vmrs_pkg::CH_CNT_RST;
            base_pw_ff <= vmrs_pkg::BASE_PW_RST;
            cyc_per_ff <= vmrs_pkg::CYCLE_RST;
        end
        else if (wr_go)
        begin
            if (hit_ctrl)
            begin
                base_pw_ff <= pwdata[vmrs_pkg::CTRL_PW_LSB +: 8];
                if (cnt_ok)
                begin
                    ch_cnt_ff <= wr_cnt;
                end
            end
            if (hit_cycle)
            begin
                cyc_per_ff <= pwdata[15:0];
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign core_enable = core_en_ff;
    assign northbridge_plane_enable = nb_en_ff;
    assign ref_out = ref_ff;
    assign power_good_output = pgood_ff;
    assign serial_code_mode = ser_mode_ff;
    assign pulse_width = pw_ff;

    // ****************************************
    // checks
    // ****************************************
    a_off_while_low: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_in |=> !core_en_ff && !nb_en_ff)
        else $error("regulator enabled while enable low");
    a_mode_held: assert property (@(posedge pclk) disable iff (!presetn)
        enable_in && $past(enable_in) |-> $stable(par_mode_ff))
        else $error("mode changed while enabled");
    a_mode_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(enable_in) |-> serial_code_mode == !$past(mode_select_pin))
        else $error("wrong mode latched");
    a_par_nb_off: assert property (@(posedge pclk) disable iff (!presetn)
        par_mode_ff |-> nb_tgt == vmrs_pkg::REF_ZERO ##1 !nb_en_ff)
        else $error("northbridge on in parallel mode");
    a_par_top_code: assert property (@(posedge pclk) disable iff (!presetn)
        par_mode_ff && par_code == 6'h00 |-> core_tgt == vmrs_pkg::REF_PAR_HI_TOP)
        else $error("parallel top code wrong");
    a_par_low_end: assert property (@(posedge pclk) disable iff (!presetn)
        par_mode_ff && par_code == vmrs_pkg::PAR_CODE_LAST |-> core_tgt == vmrs_pkg::REF_PAR_LO_END)
        else $error("parallel bottom code wrong");
    a_step_paced: assert property (@(posedge pclk) disable iff (!presetn)
        !step_tick |=> $stable(ref_ff))
        else $error("reference moved off tick");
    a_pgood_done: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pgood_ff) |-> ref_ff.core == core_tgt && ref_ff.nb == nb_tgt)
        else $error("power good before target");
    a_ramp_down: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == vmrs_pkg::ST_DOWN && !en_rise && step_tick
        && ref_ff.core != vmrs_pkg::REF_ZERO
        |=> ref_ff.core == $past(ref_ff.core) - vmrs_pkg::REF_STEP)
        else $error("reference not ramping down");
    a_pgood_drop: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_in |=> !pgood_ff)
        else $error("power good kept without enable");
    a_hold_restore: assert property (@(posedge pclk) disable iff (!presetn)
        !par_mode_ff && !fixed_voltage_strap && !power_ok_input && !en_rise
        |-> core_tgt == hold_ff && nb_tgt == hold_ff ##1 $stable(hold_ff))
        else $error("not using held startup target");
endmodule
`default_nettype wire

/* File: logic/vmrs_pkg.sv */
/*
 * Shared constants and types for the voltage-code mode and reference select block.
 * Assumes a 10 MHz pclk and an APB master that keeps to the usual setup/access order.
 */
// Behaviour
// - enable low keeps both regulators off and samples the mode pin continuously.
// - mode pin latched on enable rising edge and held until enable falls.
// - latched low selects serial code mode, latched high parallel code mode.
// - parallel code mode keeps the northbridge regulator off, core only.
// - parallel codes 0..31 give 1.5500 V falling 25 mV per code to 0.7750 V.
// - parallel codes 32..63 give 0.7625 V falling 12.5 mV per code to 0.3750 V.
// - serial mode takes both plane targets only from decoded serial inputs.
// - serial clock and data levels are read according to power-ok and fixed strap; the code reads them by the fixed strap only and never uses power-ok.
// - strap low startup codes 00/01/10/11 give 1.1/1.0/0.9/0.8 V.
// - startup codes are decoded only once power-on reset is satisfied.
// - on enable rise the startup target is stored in a holding register and used.
// - soft-start steps both plane references toward target over a fixed interval.
// - power good rises when soft-start ends.
// - enable falling ramps the references down to near zero.
// - loss of enable drops power good.
// - strap high codes 00/01/10/11 give 1.4/1.2/1.0/0.8 V.
// - each switching cycle sum active channel currents and divide by active count.
// - each channel error against the average trims its pulse width toward balance.
// - strap high soft-starts both planes to the decoded fixed level.
// - power-ok low steps both planes back to the held startup target.
package vmrs_pkg;
    // reference codes are in units of 12.5 mV
    localparam logic [7:0] REF_STEP = 8'h01;
    localparam logic [7:0] REF_ZERO = 8'h00;
    localparam logic [7:0] REF_PAR_HI_TOP = 8'h7c;
    localparam logic [7:0] REF_PAR_LO_TOP = 8'h3d;
    localparam logic [7:0] REF_PAR_LO_END = 8'h1e;
    localparam logic [5:0] PAR_LO_FIRST = 6'h20;
    localparam logic [5:0] PAR_CODE_LAST = 6'h3f;
    localparam logic [7:0] REF_1V4 = 8'h70;
    localparam logic [7:0] REF_1V2 = 8'h60;
    localparam logic [7:0] REF_1V1 = 8'h58;
    localparam logic [7:0] REF_1V0 = 8'h50;
    localparam logic [7:0] REF_0V9 = 8'h48;
    localparam logic [7:0] REF_0V8 = 8'h40;
    // step timer
    localparam int CLK_PERIOD_NS = 100;
    localparam int STEP_TIME_NS = 1000;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_AVG = 8'h0c;
    localparam int CTRL_CNT_LSB = 0;
    localparam int CTRL_PW_LSB = 8;
    localparam logic [2:0] CH_MIN = 3'h2;
    localparam logic [2:0] CH_MAX = 3'h4;
    localparam logic [2:0] CH_CNT_RST = 3'h4;
    localparam logic [7:0] BASE_PW_RST = 8'h80;
    localparam logic [15:0] CYCLE_RST = 16'h0063;
    localparam int NUM_CH = 4;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RAMP = 2'b01,
        ST_REG = 2'b10,
        ST_DOWN = 2'b11
    } vmrs_state_t;
    typedef struct packed {
        logic [7:0] core;
        logic [7:0] nb;
    } vmrs_ref_t;
endpackage

/* File: sim/vmrs_host_model.sv */
/*
 * Host-side model: processor and board driving the code and strap pins.
 * Assumes the bench changes its commands just after a rising pclk edge.
 */
`timescale 1ns/1ns
`default_nettype none
module vmrs_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_en,
    input wire logic cmd_mode,
    input wire logic cmd_por,
    input wire logic cmd_pok,
    input wire logic cmd_strap,
    input wire logic [1:0] cmd_sv,
    input wire logic [5:0] cmd_code,
    output logic enable_in,
    output logic por_ok,
    output logic mode_select_pin,
    output logic [5:0] par_code,
    output logic serial_code_clock,
    output logic serial_code_data,
    output logic power_ok_input,
    output logic fixed_voltage_strap
);
    // ****************
    // enable gated by mode pin settle time
    // ****************
    logic en_ff;
    logic sel_ff;
    logic [3:0] cnt_ff;
    // once enabled the pin carries other traffic, so it toggles
    wire logic nxt_sel = (en_ff && cmd_en) ? ~sel_ff : cmd_mode;
    wire logic settled = (sel_ff == cmd_mode) && (cnt_ff >= 4'ha);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_ff <= 1'b0;
            sel_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end
        else
        begin
            en_ff <= cmd_en & (en_ff | settled);
            sel_ff <= nxt_sel;
            cnt_ff <= (nxt_sel != sel_ff) ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hf};
        end
    end
    assign enable_in = en_ff;
    assign mode_select_pin = sel_ff;
    assign por_ok = cmd_por;
    assign par_code = cmd_code;
    assign serial_code_clock = cmd_sv[1];
    assign serial_code_data = cmd_sv[0];
    assign power_ok_input = cmd_pok;
    assign fixed_voltage_strap = cmd_strap;
endmodule
`default_nettype wire

/* File: sim/test_vid_mode_reference_select.sv */
/*
 * Self-checking bench: mode latch, targets, soft-start, balance, registers.
 * Assumes the host model drives the pins; the bench owns APB and samples.
 */
`timescale 1ns/1ns
`default_nettype none
module test_vid_mode_reference_select;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, tgt, base;
    logic [31:0] pwdata, prdata, rd, seed;
    logic c_en, c_mode, c_por, c_pok, c_strap, exp_ser;
    logic [1:0] c_sv;
    logic [5:0] c_code, cd, code_w;
    logic en_w, por_w, sel_w, svc_w, svd_w, pok_w, strap_w, core_en, nb_en, pg, ser;
    logic [3:0][7:0] cur, pw;
    logic [9:0] avg;
    logic [2:0] ch;
    vmrs_pkg::vmrs_ref_t refo, prev;
    int err_count, n_compared, cnt;

    vmrs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable_in(en_w), .por_ok(por_w), .mode_select_pin(sel_w),
        .par_code(code_w), .serial_code_clock(svc_w), .serial_code_data(svd_w),
        .power_ok_input(pok_w), .fixed_voltage_strap(strap_w), .cur_sample(cur),
        .core_enable(core_en), .northbridge_plane_enable(nb_en), .ref_out(refo),
        .power_good_output(pg), .serial_code_mode(ser), .pulse_width(pw));
    vmrs_host_model u_host (.pclk(pclk), .presetn(presetn), .cmd_en(c_en),
        .cmd_mode(c_mode), .cmd_por(c_por), .cmd_pok(c_pok), .cmd_strap(c_strap),
        .cmd_sv(c_sv), .cmd_code(c_code), .enable_in(en_w), .por_ok(por_w),
        .mode_select_pin(sel_w), .par_code(code_w), .serial_code_clock(svc_w),
        .serial_code_data(svd_w), .power_ok_input(pok_w), .fixed_voltage_strap(strap_w));

    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        n_compared++;
        if (got !== want)
        begin
            err_count++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] par_tgt(input logic [5:0] c);
        return c[5] ? 8'h3d - {3'h0, c[4:0]} : 8'h7c - {2'h0, c[4:0], 1'b0};
    endfunction
    function automatic logic [7:0] ser_tgt(input logic st, input logic [1:0] sv);
        return st ? 8'h70 - {2'h0, sv, 4'h0} : 8'h58 - {3'h0, sv, 3'h0};
    endfunction
    function automatic logic [7:0] pw_exp(input logic [7:0] b, input logic [9:0] a,
        input logic [7:0] c);
        logic [10:0] v;
        v = {3'h0, b} + {1'h0, a} - {3'h0, c};
        return v[10] ? 8'h00 : (v[9:8] != 2'h0 ? 8'hff : v[7:0]);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic power_up(input logic m, input logic st, input logic [1:0] sv,
        input logic [5:0] c);
        @(posedge pclk);
        c_mode <= m;
        c_strap <= st;
        c_sv <= sv;
        c_code <= c;
        c_en <= 1'b1;
        exp_ser = ~m;
        cnt = 0;
        while (pg !== 1'b1 && cnt < 3000)
        begin
            @(posedge pclk);
            cnt++;
        end
        chk(32'(cnt >= 10 * (tgt - 1) && cnt <= 10 * tgt + 40), 32'h1, "ramp time");
        chk(32'(core_en), 32'h1, "core on");
        chk(32'(nb_en), 32'(exp_ser), "nb on");
        chk(32'(refo.core), 32'(tgt), "core ref");
        if (!m)
            chk(32'(refo.nb), 32'(tgt), "nb ref");
    endtask
    task automatic power_down();
        @(posedge pclk);
        c_en <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'({pg, core_en, nb_en}), 32'h0, "enable loss");
        cnt = 0;
        while (refo !== 16'h0 && cnt < 3000)
        begin
            @(posedge pclk);
            cnt++;
        end
        chk(32'(refo), 32'h0, "ramp down");
    endtask

    // ****************
    // clock, watchdog, monitor and sequence
    // ****************
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        #6000000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
    always @(posedge pclk)
    begin
        if (presetn === 1'b1)
        begin
            chk(32'(refo.core + 8'h01 - prev.core <= 8'h02
                && refo.nb + 8'h01 - prev.nb <= 8'h02), 32'h1, "ref step");
            if (pg === 1'b1)
                chk(32'(ser), 32'(exp_ser), "mode held");
        end
        prev = refo;
    end
    initial
    begin
        seed = 32'hadcab53e;
        {presetn, psel, penable, pwrite, paddr, pwdata, cur} = '0;
        {c_en, c_mode, c_por, c_pok, c_strap, c_sv, c_code, exp_ser} = '0;
        c_por = 1'b1;
        err_count = 0;
        n_compared = 0;
        repeat (10) @(posedge pclk);
        chk(32'({pready, refo, pg}), 32'h0, "reset outputs");
        presetn <= 1'b1;
        apb(1'b0, vmrs_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_8004, "ctrl reset");
        apb(1'b0, vmrs_pkg::ADDR_CYCLE, 32'h0);
        chk(rd, 32'h0000_0063, "cycle reset");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], e}, 32'h1, "unmapped");
        c_por <= 1'b0;
        tgt = ser_tgt(1'b0, 2'h0);
        power_up(1'b0, 1'b0, 2'h3, 6'(rnd()));
        c_por <= 1'b1;
        power_down();
        for (int i = 0; i < 8; i++)
        begin
            tgt = ser_tgt(i[2], i[1:0]);
            power_up(1'b0, i[2], i[1:0], 6'(rnd()));
            if (!i[2])
            begin
                c_sv <= ~c_sv;
                c_pok <= 1'b1;
                repeat (20) @(posedge pclk);
                c_pok <= 1'b0;
                repeat (30) @(posedge pclk);
                chk(32'(refo), 32'({2{tgt}}), "held target");
                apb(1'b0, vmrs_pkg::ADDR_STATUS, 32'h0);
                chk({8'h0, rd[23:0]}, {8'h0, tgt, tgt, 8'h0e}, "status");
            end
            power_down();
        end
        for (int i = 0; i < 8; i++)
        begin
            cd = i < 4 ? {i[1], {5{i[0]}}} : 6'(rnd());
            tgt = par_tgt(cd);
            power_up(1'b1, 1'b0, 2'(rnd()), cd);
            ch = 3'(2 + i % 3);
            base = 8'(rnd());
            cur <= rnd();
            apb(1'b1, vmrs_pkg::ADDR_CYCLE, 32'h0000_000f);
            apb(1'b1, vmrs_pkg::ADDR_CTRL, {16'h0, base, 5'h0, ch});
            repeat (40) @(posedge pclk);
            avg = 10'h0;
            for (int k = 0; k < 4; k++)
                if (k < ch)
                    avg = avg + {2'h0, cur[k]};
            avg = avg / {7'h0, ch};
            apb(1'b0, vmrs_pkg::ADDR_AVG, 32'h0);
            chk(rd, {22'h0, avg}, "average");
            for (int k = 0; k < 4; k++)
                chk(32'(pw[k]), 32'(k < ch ? pw_exp(base, avg, cur[k]) : 8'h00), "width");
            apb(1'b1, vmrs_pkg::ADDR_CTRL, {16'h0, base, 8'h05});
            apb(1'b0, vmrs_pkg::ADDR_CTRL, 32'h0);
            chk(rd, {16'h0, base, 5'h0, ch}, "count kept");
            power_down();
        end
        final_report();
    end
endmodule
`default_nettype wire
